// ---- design/cbr_bit_timer.sv ----
// Prescaler and bit-segment timer: makes the quantum tick and the sample point.
// Assumes the receive input is synchronous to clk and recessive is high.
`timescale 1ns/1ps
`default_nettype none
module cbr_bit_timer
  import cbr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [7:0] prescale,
  input wire logic [4:0] time_segment_one,
  input wire logic [3:0] time_segment_two,
  input wire logic [2:0] sjw,
  input wire logic rx_in,
  input wire logic transmitting,
  input wire logic bus_idle,
  output logic tq_tick,
  output logic sample_tick,
  output logic sample_bit
);
  typedef struct packed {
    logic [7:0] presc;
    logic [4:0] pos;
    logic [2:0] ext;
    logic [2:0] shrink;
    logic rx_prev;
    logic smp_tick;
    logic smp_bit;
  } cbr_bt_t;

  cbr_bt_t r;
  cbr_bt_t n;
  logic [4:0] seg1_end;
  logic [4:0] bit_end;
  logic [4:0] rem;

  assign tq_tick = (r.presc == 8'h00);
  assign sample_tick = r.smp_tick;
  assign sample_bit = r.smp_bit;

  always_comb begin
    n = r;
    n.smp_tick = 1'b0;
    seg1_end = 5'(time_segment_one + {2'h0, r.ext});
    bit_end = 5'(seg1_end + {1'h0, time_segment_two} - {2'h0, r.shrink});
    rem = 5'(bit_end - r.pos);
    if (r.presc == 8'h00) begin
      n.presc = prescale;
      n.rx_prev = rx_in;
      if (r.pos >= bit_end) begin
        n.pos = 5'h00;
        n.ext = 3'h0;
        n.shrink = 3'h0;
      end else begin
        n.pos = 5'(r.pos + 5'h01);
      end
      if (r.pos == seg1_end) begin
        n.smp_tick = 1'b1;
        n.smp_bit = rx_in;
      end
      if (r.rx_prev == CBR_RECESSIVE && rx_in != CBR_RECESSIVE && !transmitting) begin
        if (bus_idle) begin
          n.pos = 5'h01;
          n.ext = 3'h0;
          n.shrink = 3'h0;
        end else if (r.pos != 5'h00 && r.pos <= seg1_end) begin
          n.ext = ({2'h0, sjw} < r.pos) ? sjw : r.pos[2:0];
        end else if (r.pos > seg1_end) begin
          if (rem < {2'h0, sjw}) begin
            n.pos = 5'h01;
            n.ext = 3'h0;
            n.shrink = 3'h0;
          end else begin
            n.shrink = sjw;
          end
        end
      end
    end else begin
      n.presc = 8'(r.presc - 8'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '{presc: 8'h00, pos: 5'h00, ext: 3'h0, shrink: 3'h0, rx_prev: CBR_RECESSIVE,
             smp_tick: 1'b0, smp_bit: CBR_RECESSIVE};
    end else if (ce) begin
      r <= n;
    end
  end
endmodule
`default_nettype wire

// ---- design/cbr_pkg.sv ----
// Constants, register map and state codes for the bus-off recovery and bit-timing block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses 8 bits wide.
package cbr_pkg;
  localparam int CBR_AW = 8;
  localparam logic [1:0] CBR_RESP_OKAY = 2'h0;
  localparam logic [1:0] CBR_RESP_SLVERR = 2'h2;
  // Register byte offsets
  localparam logic [7:0] CBR_OFF_CTRL = 8'h00;
  localparam logic [7:0] CBR_OFF_INFO = 8'h04;
  localparam logic [7:0] CBR_OFF_ERC = 8'h08;
  localparam logic [7:0] CBR_OFF_BRP = 8'h0c;
  localparam logic [7:0] CBR_OFF_BTR = 8'h10;
  // Field positions
  localparam int CBR_CTRL_MODE_LSB = 0;
  localparam int CBR_CTRL_CCE_BIT = 3;
  localparam int CBR_CTRL_PSM_LSB = 4;
  localparam int CBR_INFO_BUSOFF_FLAG_BIT = 0;
  localparam int CBR_INFO_PASV_BIT = 1;
  localparam int CBR_INFO_JOIN_BIT = 2;
  localparam int CBR_INFO_RCV_BIT = 3;
  localparam int CBR_ERC_TEC_LSB = 0;
  localparam int CBR_ERC_REC_LSB = 8;
  localparam int CBR_ERC_RPS_BIT = 15;
  localparam int CBR_BRP_LSB = 0;
  localparam int CBR_BTR_TS1_LSB = 0;
  localparam int CBR_BTR_TS2_LSB = 8;
  localparam int CBR_BTR_SJW_LSB = 12;
  // Mode and power-save codes
  localparam logic [2:0] CBR_MODE_INIT = 3'h0;
  localparam logic [1:0] CBR_PSM_NONE = 2'h0;
  localparam logic [1:0] CBR_PSM_SLEEP = 2'h1;
  localparam logic [1:0] CBR_PSM_STOP = 2'h2;
  // Bus levels and counts
  localparam logic CBR_RECESSIVE = 1'b1;
  localparam logic [3:0] CBR_RUN_LAST = 4'ha;
  localparam logic [6:0] CBR_GROUP_LAST = 7'h7f;
  localparam logic [7:0] CBR_TEC_BUSOFF_FLAG = 8'hf8;
  localparam logic [7:0] CBR_TEC_PASV = 8'h80;
  localparam logic [7:0] CBR_STEP8 = 8'h08;
  localparam logic [7:0] CBR_STEP1 = 8'h01;
  localparam logic [7:0] CBR_REC_TOP = 8'h7f;
  localparam logic [6:0] CBR_REC_PASV_RET = 7'h77;
  // Bit timing limits in time quanta
  localparam logic [4:0] CBR_TS1_MIN = 5'h02;
  localparam logic [4:0] CBR_BIT_MIN = 5'h08;
  // Reset values
  localparam logic [7:0] CBR_BRP_RST = 8'h00;
  localparam logic [3:0] CBR_TS1_RST = 4'h4;
  localparam logic [2:0] CBR_TS2_RST = 3'h2;
  localparam logic [1:0] CBR_SJW_RST = 2'h0;
  typedef enum logic [4:0] {
    CBR_ST_INIT = 5'b00001,
    CBR_ST_RECOVER = 5'b00010,
    CBR_ST_OPER = 5'b00100,
    CBR_ST_SLEEP = 5'b01000,
    CBR_ST_STOP = 5'b10000
  } cbr_state_t;
endpackage

// ---- design/cbr_top.sv ----
// Bus-off recovery, error counters, mode control and bit timing of a CAN controller.
// Assumes an AXI4-Lite master, a protocol engine that reports errors, and a transceiver.
`timescale 1ns/1ps
`default_nettype none
module cbr_top
  import cbr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [cbr_pkg::CBR_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cbr_pkg::CBR_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic can_rx_in,
  output logic can_tx_out,
  input wire logic proto_tx_bit,
  input wire logic transmitting,
  input wire logic bus_idle,
  input wire logic err_det,
  input wire logic err_is_tx,
  input wire logic err_weight8,
  input wire logic err_in_intermission,
  input wire logic flag_done,
  input wire logic tx_ok,
  input wire logic rx_ok,
  output logic flag_start,
  output logic flag_passive,
  output logic overload_start,
  output logic tq_tick,
  output logic sample_tick,
  output logic sample_bit
);
  typedef struct packed {
    cbr_state_t st;
    logic [2:0] mode_req;
    logic [1:0] psm;
    logic cce;
    logic busoff;
    logic joined;
    logic [7:0] tx_error_count;
    logic [6:0] rx_error_count;
    logic rec_pas;
    logic [3:0] run;
    logic pend;
    logic pend_tx;
    logic pend8;
    logic flag_start;
    logic flag_passive;
    logic ovl_start;
    logic tx_q;
    logic rx_d;
    logic [7:0] brp;
    logic [3:0] ts1;
    logic [2:0] ts2;
    logic [1:0] sjw;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } cbr_regs_t;

  cbr_regs_t r;
  cbr_regs_t n;
  logic [32:0] rd_ar;
  logic [32:0] rd_aw;
  logic [31:0] wr_data;
  logic do_write;
  logic ctrl_w;
  logic clear_cnt;
  logic group;
  logic wake;
  logic passive;
  logic active;
  logic [7:0] rec_sum;
  logic [4:0] ts1_raw;
  logic [4:0] ts1_len;
  logic [4:0] ts1_fit;
  logic [3:0] ts2_len;
  logic [4:0] sjw_raw;
  logic [2:0] sjw_fit;
  logic bt_tick;
  logic bt_bit;

  // Read decode: bit 32 is the hit flag, the rest is the register word
  function automatic logic [32:0] cbr_read(input cbr_regs_t s, input logic [7:0] a);
    logic [31:0] d;
    logic hit;
    d = 32'h0000_0000;
    hit = 1'b1;
    case ({a[7:2], 2'b00})
      CBR_OFF_CTRL: begin
        // mode field reads zero in init and recovery
        if (s.st == CBR_ST_OPER || s.st == CBR_ST_SLEEP || s.st == CBR_ST_STOP) begin
          d[CBR_CTRL_MODE_LSB +: 3] = s.mode_req;
        end
        d[CBR_CTRL_CCE_BIT] = s.cce;
        d[CBR_CTRL_PSM_LSB +: 2] = s.psm;
      end
      CBR_OFF_INFO: begin
        d[CBR_INFO_BUSOFF_FLAG_BIT] = s.busoff;
        d[CBR_INFO_PASV_BIT] = (s.tx_error_count >= CBR_TEC_PASV) || s.rec_pas;
        d[CBR_INFO_JOIN_BIT] = s.joined;
        d[CBR_INFO_RCV_BIT] = (s.st == CBR_ST_RECOVER);
      end
      CBR_OFF_ERC: begin
        d[CBR_ERC_TEC_LSB +: 8] = s.tx_error_count;
        d[CBR_ERC_REC_LSB +: 7] = s.rx_error_count;
        d[CBR_ERC_RPS_BIT] = s.rec_pas;
      end
      CBR_OFF_BRP: d[CBR_BRP_LSB +: 8] = s.brp;
      CBR_OFF_BTR: begin
        d[CBR_BTR_TS1_LSB +: 4] = s.ts1;
        d[CBR_BTR_TS2_LSB +: 3] = s.ts2;
        d[CBR_BTR_SJW_LSB +: 2] = s.sjw;
      end
      default: hit = 1'b0;
    endcase
    return {hit, d};
  endfunction

  function automatic logic [31:0] cbr_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  assign s_axi_awready = !r.aw_have && !r.bvalid;
  assign s_axi_wready = !r.w_have && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign can_tx_out = r.tx_q;
  assign flag_start = r.flag_start;
  assign flag_passive = r.flag_passive;
  assign overload_start = r.ovl_start;
  assign sample_tick = bt_tick;
  assign sample_bit = bt_bit;

  // first segment held at 2 quanta or more
  assign ts1_raw = 5'({1'b0, r.ts1} + 5'h01);
  assign ts1_len = (ts1_raw < CBR_TS1_MIN) ? CBR_TS1_MIN : ts1_raw;
  assign ts2_len = 4'({1'b0, r.ts2} + 4'h1);
  // short settings stretch segment one up to 8 quanta per bit
  assign ts1_fit = (5'(ts1_len + {1'b0, ts2_len} + 5'h01) < CBR_BIT_MIN) ?
                   5'(CBR_BIT_MIN - 5'h01 - {1'b0, ts2_len}) : ts1_len;
  // jump width kept below segment one
  assign sjw_raw = 5'({3'h0, r.sjw} + 5'h01);
  assign sjw_fit = (sjw_raw > 5'(ts1_fit - 5'h01)) ? 3'(ts1_fit - 5'h01) : sjw_raw[2:0];

  cbr_bit_timer u_bit_timer (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .prescale(r.brp),
    .time_segment_one(ts1_fit),
    .time_segment_two(ts2_len),
    .sjw(sjw_fit),
    .rx_in(can_rx_in),
    .transmitting(transmitting),
    .bus_idle(bus_idle),
    .tq_tick(tq_tick),
    .sample_tick(bt_tick),
    .sample_bit(bt_bit)
  );

  always_comb begin
    n = r;
    n.cce = 1'b0;
    n.flag_start = 1'b0;
    n.ovl_start = 1'b0;
    n.rx_d = can_rx_in;
    clear_cnt = 1'b0;
    group = 1'b0;
    ctrl_w = 1'b0;
    passive = (r.tx_error_count >= CBR_TEC_PASV) || r.rec_pas;
    active = (r.st == CBR_ST_OPER) && r.joined && !r.busoff;
    rec_sum = 8'({1'b0, r.rx_error_count} + (r.pend8 ? CBR_STEP8 : CBR_STEP1));
    rd_ar = cbr_read(r, s_axi_araddr);
    rd_aw = cbr_read(r, r.awaddr);
    wr_data = cbr_merge(rd_aw[31:0], r.wdata, r.wstrb);
    do_write = r.aw_have && r.w_have && !r.bvalid;

    // Register bus
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_have = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_have = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rdata = rd_ar[31:0];
      n.rresp = rd_ar[32] ? CBR_RESP_OKAY : CBR_RESP_SLVERR;
    end
    if (do_write) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = rd_aw[32] ? CBR_RESP_OKAY : CBR_RESP_SLVERR;
      case ({r.awaddr[7:2], 2'b00})
        CBR_OFF_CTRL: ctrl_w = 1'b1;
        CBR_OFF_BRP: n.brp = wr_data[CBR_BRP_LSB +: 8];
        CBR_OFF_BTR: begin
          n.ts1 = wr_data[CBR_BTR_TS1_LSB +: 4];
          n.ts2 = wr_data[CBR_BTR_TS2_LSB +: 3];
          n.sjw = wr_data[CBR_BTR_SJW_LSB +: 2];
        end
        default: ;
      endcase
    end

    // Mode control
    if (ctrl_w) begin
      n.psm = wr_data[CBR_CTRL_PSM_LSB +: 2];
      n.cce = wr_data[CBR_CTRL_CCE_BIT];
      case (r.st)
        CBR_ST_INIT: begin
          // counter clear in init, also with a mode request
          clear_cnt = wr_data[CBR_CTRL_CCE_BIT];
          if (wr_data[CBR_CTRL_MODE_LSB +: 3] != CBR_MODE_INIT) begin
            n.mode_req = wr_data[CBR_CTRL_MODE_LSB +: 3];
            if (r.busoff && !wr_data[CBR_CTRL_CCE_BIT]) begin
              n.st = CBR_ST_RECOVER;
              n.rx_error_count = 7'h00;
            end else begin
              // forced entry, joining waits for idle bus
              n.st = CBR_ST_OPER;
              n.joined = 1'b0;
            end
          end
        end
        CBR_ST_RECOVER, CBR_ST_OPER: begin
          // sleep allowed while bus-off; clear ignored here
          if (wr_data[CBR_CTRL_PSM_LSB +: 2] == CBR_PSM_SLEEP) begin
            n.st = CBR_ST_SLEEP;
          end else if (wr_data[CBR_CTRL_MODE_LSB +: 3] == CBR_MODE_INIT) begin
            n.st = CBR_ST_INIT;
          end else if (r.st == CBR_ST_OPER) begin
            n.mode_req = wr_data[CBR_CTRL_MODE_LSB +: 3];
          end
        end
        CBR_ST_SLEEP: begin
          if (wr_data[CBR_CTRL_PSM_LSB +: 2] == CBR_PSM_STOP) begin
            n.st = CBR_ST_STOP;
          end else if (wr_data[CBR_CTRL_PSM_LSB +: 2] == CBR_PSM_NONE) begin
            n.st = r.busoff ? CBR_ST_RECOVER : CBR_ST_OPER;
            n.rx_error_count = r.busoff ? 7'h00 : r.rx_error_count;
            n.joined = 1'b0;
          end
        end
        CBR_ST_STOP: begin
          if (wr_data[CBR_CTRL_PSM_LSB +: 2] == CBR_PSM_SLEEP) begin
            n.st = CBR_ST_SLEEP;
          end
        end
        default: n.st = CBR_ST_INIT;
      endcase
    end

    // dominant edge wakes; power-save field left for software
    wake = (r.st == CBR_ST_SLEEP) && (r.rx_d == CBR_RECESSIVE) && (can_rx_in != CBR_RECESSIVE);
    if (wake) begin
      n.st = r.busoff ? CBR_ST_RECOVER : CBR_ST_OPER;
      n.rx_error_count = r.busoff ? 7'h00 : r.rx_error_count;
      n.joined = 1'b0;
    end

    // Runs of 11 recessive bits
    if (bt_tick) begin
      if (bt_bit == CBR_RECESSIVE) begin
        if (r.run == CBR_RUN_LAST) begin
          group = 1'b1;
          n.run = 4'h0;
        end else begin
          n.run = 4'(r.run + 4'h1);
        end
      end else begin
        n.run = 4'h0;
      end
    end
    if (group && r.st == CBR_ST_RECOVER && n.st == CBR_ST_RECOVER) begin
      if (r.rx_error_count == CBR_GROUP_LAST) begin
        n.tx_error_count = 8'h00;
        n.rx_error_count = 7'h00;
        n.rec_pas = 1'b0;
        n.busoff = 1'b0;
        n.st = CBR_ST_OPER;
        n.joined = 1'b1;
      end else begin
        n.rx_error_count = 7'(r.rx_error_count + 7'h01);
      end
    end
    if (group && r.st == CBR_ST_OPER && !r.joined) begin
      n.joined = 1'b1;
    end

    // Error signalling
    if (active && err_det) begin
      if (err_in_intermission) begin
        n.ovl_start = 1'b1;
      end else begin
        n.flag_start = 1'b1;
        n.flag_passive = passive;
        n.pend = 1'b1;
        n.pend_tx = err_is_tx;
        n.pend8 = err_weight8;
      end
    end
    // counters change once the flag is out
    if (r.pend && flag_done) begin
      n.pend = 1'b0;
      if (r.pend_tx) begin
        if (r.tx_error_count >= CBR_TEC_BUSOFF_FLAG) begin
          n.busoff = 1'b1;
        end else begin
          n.tx_error_count = 8'(r.tx_error_count + CBR_STEP8);
        end
      end else if (rec_sum > CBR_REC_TOP) begin
        n.rx_error_count = CBR_REC_TOP[6:0];
        n.rec_pas = 1'b1;
      end else begin
        n.rx_error_count = rec_sum[6:0];
      end
    end
    if (active && tx_ok && r.tx_error_count != 8'h00) begin
      n.tx_error_count = 8'(r.tx_error_count - CBR_STEP1);
    end
    if (active && rx_ok) begin
      if (r.rec_pas) begin
        n.rx_error_count = CBR_REC_PASV_RET;
        n.rec_pas = 1'b0;
      end else if (r.rx_error_count != 7'h00) begin
        n.rx_error_count = 7'(r.rx_error_count - 7'h01);
      end
    end
    if (clear_cnt) begin
      n.tx_error_count = 8'h00;
      n.rx_error_count = 7'h00;
      n.rec_pas = 1'b0;
      n.busoff = 1'b0;
      n.pend = 1'b0;
    end

    // recessive output while bus-off or not joined
    n.tx_q = active ? proto_tx_bit : CBR_RECESSIVE;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
      r.st <= CBR_ST_INIT;
      r.tx_q <= CBR_RECESSIVE;
      r.rx_d <= CBR_RECESSIVE;
      r.brp <= CBR_BRP_RST;
      r.ts1 <= CBR_TS1_RST;
      r.ts2 <= CBR_TS2_RST;
      r.sjw <= CBR_SJW_RST;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/cbr_bus_node.sv ----
// Other nodes on the bus, seen through the transceiver.
// Assumes a pulled-up bus that reads recessive unless a node drives it.
`timescale 1ns/1ps
`default_nettype none
module cbr_bus_node #(
  parameter int DOM_CLKS = 9
) (
  input wire logic clk,
  input wire logic wake,
  output logic can_rx_in
);
  int cnt = 0;
  always @(posedge clk) begin
    if (wake) cnt <= DOM_CLKS;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  assign can_rx_in = (cnt == 0);
endmodule
`default_nettype wire

// ---- testbench/cbr_top_asserts.sv ----
// Checker bound to the bus-off recovery top, watching its ports only.
// Assumes the clock enable is held high.
`timescale 1ns/1ps
`default_nettype none
module cbr_top_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic proto_tx_bit,
  input wire logic can_tx_out,
  input wire logic err_det,
  input wire logic err_in_intermission,
  input wire logic flag_start,
  input wire logic flag_passive,
  input wire logic overload_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  tx_follow_a: assert property (!can_tx_out |-> !$past(proto_tx_bit))
    else $error("tx dominant without request");
  flag_cause_a: assert property (flag_start |-> $past(err_det) && !$past(err_in_intermission))
    else $error("flag without plain error");
  overload_only_a: assert property (err_det && err_in_intermission |=> !flag_start)
    else $error("error flag in intermission");
  overload_cause_a: assert property (overload_start |-> $past(err_in_intermission))
    else $error("overload without cause");
  flag_pulse_a: assert property (flag_start |=> !flag_start)
    else $error("flag start too long");
  passive_hold_a: assert property ($changed(flag_passive) |-> flag_start || $past(flag_start))
    else $error("flag type changed alone");
  wr_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind cbr_top cbr_top_asserts i_chk (.clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .proto_tx_bit,
  .can_tx_out, .err_det, .err_in_intermission, .flag_start, .flag_passive, .overload_start);
`default_nettype wire

// ---- testbench/cbr_top_tb.sv ----
// Self-checking bench for the bus-off recovery block.
// Assumes the bus node model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module cbr_top_tb;
  import cbr_pkg::*;
  logic clk = 0, srst = 1, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, bp;
  logic [31:0] s_axi_wdata = 0, v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_arvalid = 0, s_axi_rready = 0, proto_tx_bit = 1, transmitting = 0, bus_idle = 0;
  logic err_det = 0, err_is_tx = 1, err_weight8 = 0, err_in_intermission = 0, flag_done = 0;
  logic tx_ok = 0, rx_ok = 0, wake = 0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic can_rx_in, can_tx_out, flag_start, flag_passive, overload_start;
  wire logic tq_tick, sample_tick, sample_bit;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int miscompares = 0, checks_done = 0;
  logic [33:0] expq[$], mskq[$];
  logic [2:0] md;
  time t0;
  cbr_top i_dut (.clk, .srst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .can_rx_in, .can_tx_out, .proto_tx_bit, .transmitting, .bus_idle, .err_det,
    .err_is_tx, .err_weight8, .err_in_intermission, .flag_done, .tx_ok, .rx_ok, .flag_start,
    .flag_passive, .overload_start, .tq_tick, .sample_tick, .sample_bit);
  cbr_bus_node i_node (.clk, .wake, .can_rx_in);
  always #4 clk = ~clk;
  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    logic [1:0] rs;
    tb = 0;
    rs = 2'h0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    cmp(34'(rs), 34'((a > CBR_OFF_BTR) ? CBR_RESP_SLVERR : CBR_RESP_OKAY));
  endtask
  // Expectation queued here, checked by the read monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic t, ta;
    t = 0;
    ta = 0;
    expq.push_back({(a > CBR_OFF_BTR) ? CBR_RESP_SLVERR : CBR_RESP_OKAY, e & m});
    mskq.push_back({2'h3, m});
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!t) begin
      @(negedge clk);
      ta = s_axi_arready;
      t = s_axi_rvalid;
      v = s_axi_rdata;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    int n;
    n = 0;
    rd(a, 0, 0);
    while ((v & m) !== x && n < 8000) begin
      rd(a, 0, 0);
      n++;
    end
    if ((v & m) !== x) miscompares++;
  endtask
  task automatic terr(input int n);
    repeat (n) begin
      @(posedge clk);
      err_det <= 1'b1;
      err_weight8 <= 1'($urandom);
      @(posedge clk);
      err_det <= 1'b0;
      repeat (3) @(posedge clk);
      flag_done <= 1'b1;
      @(posedge clk);
      flag_done <= 1'b0;
    end
  endtask
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      if (expq.size() == 0) cmp(34'h0, 34'h1);
      else cmp({s_axi_rresp, s_axi_rdata} & mskq.pop_front(), expq.pop_front());
    end
  end
  initial begin
    v = $urandom(63);
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(CBR_OFF_BRP, 0, 32'hff);
    rd(CBR_OFF_BTR, 32'h0204, 32'h370f);
    wr(8'h14, $urandom);
    rd(8'h14, 0, 32'hffffffff);
    $display("done: reset values");
    md = 3'($urandom_range(7, 1));
    wr(CBR_OFF_CTRL, {29'h0, md});
    poll(CBR_OFF_INFO, 32'h4, 32'h4);
    rd(CBR_OFF_CTRL, {29'h0, md}, 32'h3f);
    proto_tx_bit <= 1'b0;
    err_in_intermission <= 1'b1;
    terr(1);
    err_in_intermission <= 1'b0;
    rd(CBR_OFF_ERC, 0, 32'hffff);
    cmp(34'(can_tx_out), 34'h0);
    terr(31);
    rd(CBR_OFF_ERC, 32'hf8, 32'hffff);
    terr(1);
    rd(CBR_OFF_ERC, 32'hf8, 32'hffff);
    rd(CBR_OFF_INFO, 32'h1, 32'h1);
    cmp(34'(can_tx_out), 34'h1);
    $display("done: bus-off entry");
    wr(CBR_OFF_CTRL, 0);
    rd(CBR_OFF_CTRL, 0, 32'h7);
    wr(CBR_OFF_CTRL, {29'h0, md});
    repeat (300) @(posedge clk);
    rd(CBR_OFF_CTRL, 0, 32'h7);
    rd(CBR_OFF_INFO, 32'h9, 32'h9);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    wr(CBR_OFF_CTRL, 0);
    wr(CBR_OFF_CTRL, {29'h0, md});
    t0 = $time;
    rd(CBR_OFF_ERC, 0, 32'h7f00);
    poll(CBR_OFF_INFO, 32'h1, 32'h0);
    cmp(34'(($time - t0) inside {[100500:101800]}), 34'h1);
    rd(CBR_OFF_ERC, 0, 32'hffff);
    rd(CBR_OFF_CTRL, {29'h0, md}, 32'h7);
    $display("done: normal recovery");
    terr(32);
    wr(CBR_OFF_CTRL, 0);
    wr(CBR_OFF_CTRL, {28'h1, md});
    rd(CBR_OFF_CTRL, {29'h0, md}, 32'hf);
    rd(CBR_OFF_INFO, 0, 32'h1);
    rd(CBR_OFF_ERC, 0, 32'hffff);
    poll(CBR_OFF_INFO, 32'h4, 32'h4);
    terr(2);
    wr(CBR_OFF_CTRL, {28'h1, md});
    rd(CBR_OFF_ERC, 32'h10, 32'hffff);
    {tx_ok, rx_ok} <= 2'h3;
    @(posedge clk);
    {tx_ok, rx_ok} <= 2'h0;
    rd(CBR_OFF_ERC, 32'h0f, 32'hffff);
    $display("done: forced recovery");
    terr(40);
    wr(CBR_OFF_CTRL, {28'h1, md});
    wr(CBR_OFF_CTRL, 32'h10);
    rd(CBR_OFF_CTRL, {28'h2, md}, 32'h37);
    wr(CBR_OFF_CTRL, 32'h10);
    rd(CBR_OFF_CTRL, {28'h2, md}, 32'h37);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (12) @(posedge clk);
    rd(CBR_OFF_INFO, 32'h9, 32'h9);
    rd(CBR_OFF_CTRL, 32'h10, 32'h37);
    wr(CBR_OFF_CTRL, 0);
    rd(CBR_OFF_CTRL, 0, 32'h37);
    $display("done: sleep wake");
    bp = 8'($urandom_range(40, 1));
    wr(CBR_OFF_BRP, {24'h0, bp});
    @(posedge tq_tick);
    t0 = $time;
    @(posedge tq_tick);
    cmp(34'(($time - t0) / 8), 34'(bp) + 34'h1);
    @(posedge sample_tick);
    t0 = $time;
    @(posedge sample_tick);
    cmp(34'(($time - t0) / 8),
        34'((int'(bp) + 1) * (int'(CBR_TS1_RST) + int'(CBR_TS2_RST) + 3)));
    @(negedge clk);
    cmp(34'(sample_bit), 34'h1);
    $display("done: prescaler");
    conclude();
  end
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
